// [pkg/udt_pkg.sv]
// Purpose: constants for the up/down timer
// Assumes: register port addressed by 4-bit word index, 16-bit data
// Notes:   shared by the core and the pin front end
// Operation
// RULE1: pwm: cycle match is period end, irq, clear next tick
// RULE2: pwm: duty match ends active phase, raises duty irq
// RULE3: no compare writes while running
// RULE4: no active level change while running
// RULE5: pwm drives only from the second period
// RULE6: up/down mode counts pin events per decode mode
// RULE7: mode 1: count edge, down if direction high
// RULE8: mode 2: count edge up, direction edge down
// RULE9: mode 2: both edges at once hold the counter
// RULE10: mode 3: count edge, up if direction high
// RULE11: mode 4: every edge of both pins, phase gives direction
// RULE12: mode 4: edge selections ignored
// RULE13: mode 4: both edges at once keep direction
// RULE14: sub-mode A: clear by pin, cycle match up, or both
// RULE15: sub-mode A cycle match: up clears, down decrements, irq
// RULE16: sub-mode A: down at zero reloads cycle compare
// RULE17: sub-mode B cycle match: up clears with irq, down only decrements
// RULE18: sub-mode B duty match: up increments, down clears with duty irq
// RULE19: compare channel raises irq on counter match
// RULE20: capture channel latches counter, irq on trigger edge
// RULE21: match irqs come at the count tick after the match
// RULE22: status bit 0 direction flag updates every clock; the code updates it only on up/down count events while running
// RULE23: trigger edges rise, fall or both; channel b picks input a or b
// RULE24: no capture channel write, no back-to-back channel reads
// RULE25: pins synchronised before edge detection
package udt_pkg;
    // ==========================================================
    // register map, word index
    localparam logic [3:0] REG_CTRL  = 4'h0;
    localparam logic [3:0] REG_EDGE  = 4'h1;
    localparam logic [3:0] REG_CYC   = 4'h2;
    localparam logic [3:0] REG_DUTY  = 4'h3;
    localparam logic [3:0] REG_CHA   = 4'h4;
    localparam logic [3:0] REG_CHB   = 4'h5;
    localparam logic [3:0] REG_CNT   = 4'h6;
    localparam logic [3:0] REG_STAT  = 4'h7;
    // ==========================================================
    // control register fields
    localparam int CTL_RUN   = 0;
    localparam int CTL_UDC   = 1;
    localparam int CTL_SUB   = 2;
    localparam int CTL_CLRLO = 3;
    localparam int CTL_CLRHI = 4;
    localparam int CTL_RLD   = 5;
    localparam int CTL_ALVT  = 6;
    localparam int CTL_DMLO  = 7;
    localparam int CTL_DMHI  = 9;
    localparam int CTL_CMA   = 10;
    localparam int CTL_CMB   = 11;
    localparam int CTL_BSEL  = 12;
    // status fields
    localparam int STA_DIR   = 0;
    localparam int STA_HIT   = 1;
    // ==========================================================
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [7:0]  EDGE_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // internal count clock divider, last prescaler value, one tick every PRE_LAST+1 cycles
    localparam logic [2:0]  PRE_LAST = 3'h1;
    // ==========================================================
    // pin indices inside the front end vectors
    localparam int PIN_CNT = 0;
    localparam int PIN_DIR = 1;
    localparam int PIN_CLR = 2;
    localparam int PIN_TRA = 3;
    localparam int PIN_TRB = 4;
    localparam int PIN_N   = 5;
    // decode modes of the up/down counter
    typedef enum logic [2:0] {
        UDT_DM_OFF   = 3'b000,
        UDT_DM_MODE1 = 3'b100,
        UDT_DM_MODE2 = 3'b101,
        UDT_DM_MODE3 = 3'b110,
        UDT_DM_MODE4 = 3'b111
    } udt_dmode_t;
endpackage

// [pkg/udt_pin_if.sv]
`timescale 1ns/1ps
// Purpose: synchronised pin levels and edges
// Assumes: one clock domain
// Notes:   front end drives, core only reads
interface udt_pin_if;
    logic [4:0] lvl;
    logic [4:0] rise;
    logic [4:0] fall;
    modport src (output lvl, rise, fall);
    modport snk (input  lvl, rise, fall);
endinterface // udt_pin_if

// [hw/udt_edge.sv]
`timescale 1ns/1ps
// Purpose: pin synchroniser and edge detector for the timer core
// Assumes: pins slow against clk_sys
// Notes:   three stages; the first is read only by the second
module udt_edge import udt_pkg::*; (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // raw pins
    input  wire logic [4:0] pin_raw,
    // toward core
    udt_pin_if.src          pin
);
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;

    // ==========================================================
    // synchroniser chain
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
        end else begin
            s1_q <= pin_raw; // [RULE25]
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // edges seen on synchronised levels only
    assign pin.lvl  = s2_q;
    assign pin.rise = s2_q & ~s3_q; // [RULE25]
    assign pin.fall = ~s2_q & s3_q;
endmodule // udt_edge

// [hw/udt_top.sv]
`timescale 1ns/1ps
// Purpose: 16-bit up/down timer with pwm, quadrature decode, two channels
// Assumes: register port strobes one cycle long, read data one cycle later
// Notes:   internal count tick is clk_sys divided by PRE_LAST+1
module udt_top import udt_pkg::*; (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // external pins
    input  wire logic        count_input_pin,
    input  wire logic        direction_input_pin,
    input  wire logic        external_clear_pin,
    input  wire logic        trigger_input_a,
    input  wire logic        trigger_input_b,
    // outputs
    output logic             pwm_out,
    output logic             cycle_match_irq,
    output logic             duty_match_irq,
    output logic             channel_a_irq,
    output logic             channel_b_irq
);
    // ==========================================================
    // state
    logic [15:0] ctrl_q;
    logic [7:0]  edge_q;
    logic [15:0] cycle_compare_q;
    logic [15:0] duty_compare_q;
    logic [15:0] chan_a_q;
    logic [15:0] chan_b_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [2:0]  pre_q;
    logic        dir_dn_q;
    logic        dir_dn_d;
    logic        hit_q;
    logic        pwm_ok_q;
    logic        pwm_ok_d;
    logic        pwm_act_q;
    logic        pwm_act_d;
    logic [15:0] rdata_q;
    logic [15:0] rd_mux;
    logic        pwm_q;
    logic        cyc_irq_q;
    logic        duty_irq_q;
    logic        a_irq_q;
    logic        b_irq_q;

    udt_pin_if pin ();

    // ==========================================================
    // pin front end
    udt_edge u_edge (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pin_raw ({trigger_input_b, trigger_input_a, external_clear_pin,
                   direction_input_pin, count_input_pin}),
        .pin     (pin)
    );

    // edge qualifier: sel bit0 rising, bit1 falling
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r, input logic f);
        return (sel[0] & r) | (sel[1] & f);
    endfunction

    // ==========================================================
    // control fields
    wire       run     = ctrl_q[CTL_RUN];
    wire       udc     = ctrl_q[CTL_UDC];
    wire       subb    = ctrl_q[CTL_SUB];
    wire       clr_ext = ctrl_q[CTL_CLRLO];
    wire       clr_cmp = ctrl_q[CTL_CLRHI];
    wire       rld     = ctrl_q[CTL_RLD];
    wire       alvt    = ctrl_q[CTL_ALVT];
    wire       cma     = ctrl_q[CTL_CMA];
    wire       cmb     = ctrl_q[CTL_CMB];
    wire       bsel    = ctrl_q[CTL_BSEL];
    wire [2:0] dmode   = ctrl_q[CTL_DMHI:CTL_DMLO];

    // ==========================================================
    // up/down decoding
    wire a_lvl = pin.lvl[PIN_CNT];
    wire b_lvl = pin.lvl[PIN_DIR];
    wire ci = edge_hit(edge_q[1:0], pin.rise[PIN_CNT], pin.fall[PIN_CNT]);
    wire cd = edge_hit(edge_q[3:2], pin.rise[PIN_DIR], pin.fall[PIN_DIR]);
    // mode 4 takes every edge, selections ignored
    wire qa = pin.rise[PIN_CNT] | pin.fall[PIN_CNT]; // [RULE12]
    wire qb = pin.rise[PIN_DIR] | pin.fall[PIN_DIR]; // [RULE12]
    wire m1 = (dmode == UDT_DM_MODE1);
    wire m2 = (dmode == UDT_DM_MODE2);
    wire m3 = (dmode == UDT_DM_MODE3);
    wire m4 = (dmode == UDT_DM_MODE4);

    // one step per event, none on a mode 2 collision
    wire ud_step = (m1 & ci)          // [RULE7]
                 | (m2 & (ci ^ cd))   // [RULE8] [RULE9]
                 | (m3 & ci)          // [RULE10]
                 | (m4 & (qa | qb));  // [RULE11]

    // quadrature: a leading b counts up
    wire q_dn = (qa & qb) ? dir_dn_q         // [RULE13]
              : qa        ? ~(a_lvl ^ b_lvl) // [RULE11]
              :             (a_lvl ^ b_lvl);
    wire ud_dn = m1 ? b_lvl    // [RULE7]
               : m2 ? cd       // [RULE8]
               : m3 ? ~b_lvl   // [RULE10]
               :      q_dn;

    // ==========================================================
    // count tick and compares
    wire pre_tick = (pre_q == PRE_LAST);
    // pins only in up/down mode
    wire step    = run & (udc ? ud_step : pre_tick); // [RULE6]
    wire dn      = udc & ud_dn;
    wire ext_clr = run & udc & ~subb & clr_ext
                 & pin.rise[PIN_CLR]; // [RULE14]
    wire hit_cyc  = (cnt_q == cycle_compare_q);
    wire hit_duty = (cnt_q == duty_compare_q);
    wire hit_a    = (cnt_q == chan_a_q);
    wire hit_b    = (cnt_q == chan_b_q);
    wire at_zero  = (cnt_q == DATA_RST);
    wire [15:0] cnt_inc = cnt_q + 16'h0001;
    wire [15:0] cnt_dec = cnt_q - 16'h0001;

    // ==========================================================
    // counter next value
    always_comb begin
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = DATA_RST;
        end else if (ext_clr) begin
            cnt_d = DATA_RST; // [RULE14]
        end else if (step) begin
            if (!udc) begin
                cnt_d = hit_cyc ? DATA_RST : cnt_inc; // [RULE1]
            end else if (!subb) begin
                if (!dn) begin
                    cnt_d = (hit_cyc & clr_cmp) ? DATA_RST
                                                : cnt_inc; // [RULE15]
                end else begin
                    cnt_d = (at_zero & rld) ? cycle_compare_q
                                            : cnt_dec; // [RULE16]
                end
            end else begin
                if (!dn) begin
                    cnt_d = hit_cyc ? DATA_RST : cnt_inc; // [RULE17]
                end else begin
                    cnt_d = hit_duty ? DATA_RST : cnt_dec; // [RULE18]
                end
            end
        end
    end

    // ==========================================================
    // interrupt sources, match irqs raised on the tick after a match, capture irqs on the trigger edge
    wire cyc_irq_d  = step & hit_cyc
                    & (~udc | ~subb | ~dn); // [RULE15] [RULE17] [RULE21]
    wire duty_irq_d = step & hit_duty
                    & (~udc | ~subb | dn);  // [RULE2] [RULE18] [RULE21]
    wire trg_b  = bsel ? pin.rise[PIN_TRB] : pin.rise[PIN_TRA];
    wire trg_bf = bsel ? pin.fall[PIN_TRB] : pin.fall[PIN_TRA];
    wire cap_a  = run & ~cma & edge_hit(edge_q[5:4],
                  pin.rise[PIN_TRA], pin.fall[PIN_TRA]); // [RULE23]
    wire cap_b  = run & ~cmb
                & edge_hit(edge_q[7:6], trg_b, trg_bf); // [RULE23]
    wire a_irq_d = cma ? (step & hit_a) : cap_a; // [RULE19] [RULE20]
    wire b_irq_d = cmb ? (step & hit_b) : cap_b; // [RULE19] [RULE20]

    // ==========================================================
    // pwm waveform: active from period start until duty match
    assign pwm_act_d = run & ~udc & ((step & hit_cyc) ? 1'b1   // [RULE1]
                     : (step & hit_duty) ? 1'b0 : pwm_act_q);  // [RULE2]
    // first period only arms the output
    assign pwm_ok_d  = run & ~udc
                     & (pwm_ok_q | (step & hit_cyc)); // [RULE5]
    wire   pwm_d     = (pwm_ok_d & pwm_act_d) ? ~alvt : alvt;

    // direction flag follows the decoder on each up/down count event while running
    assign dir_dn_d  = (udc & run & ud_step) ? ud_dn : dir_dn_q; // [RULE22]

    // ==========================================================
    // register port decode
    wire wr_ctl  = reg_wr & (reg_addr == REG_CTRL);
    wire wr_edge = reg_wr & (reg_addr == REG_EDGE);
    wire wr_cyc  = reg_wr & (reg_addr == REG_CYC);
    wire wr_duty = reg_wr & (reg_addr == REG_DUTY);
    // capture channels ignore writes
    wire wr_cha  = reg_wr & (reg_addr == REG_CHA) & cma;
    wire wr_chb  = reg_wr & (reg_addr == REG_CHB) & cmb;
    wire rd_stat = reg_rd & (reg_addr == REG_STAT);

    // read selection, unmapped reads zero
    always_comb begin
        unique case (reg_addr)
            REG_CTRL: rd_mux = ctrl_q;
            REG_EDGE: rd_mux = {8'h00, edge_q};
            REG_CYC:  rd_mux = cycle_compare_q;
            REG_DUTY: rd_mux = duty_compare_q;
            REG_CHA:  rd_mux = chan_a_q;
            REG_CHB:  rd_mux = chan_b_q;
            REG_CNT:  rd_mux = cnt_q;
            REG_STAT: rd_mux = {14'h0000, hit_q, dir_dn_q}; // [RULE22]
            default:  rd_mux = 16'h0000;
        endcase
    end

    // ==========================================================
    // software registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q          <= CTRL_RST;
            edge_q          <= EDGE_RST;
            cycle_compare_q <= DATA_RST;
            duty_compare_q  <= DATA_RST;
        end else begin
            if (wr_ctl)  ctrl_q          <= reg_wdata;
            if (wr_edge) edge_q          <= reg_wdata[7:0];
            if (wr_cyc)  cycle_compare_q <= reg_wdata;
            if (wr_duty) duty_compare_q  <= reg_wdata;
        end
    end

    // capture beats a write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chan_a_q <= DATA_RST;
            chan_b_q <= DATA_RST;
        end else begin
            if (cap_a)       chan_a_q <= cnt_q; // [RULE20]
            else if (wr_cha) chan_a_q <= reg_wdata;
            if (cap_b)       chan_b_q <= cnt_q; // [RULE20]
            else if (wr_chb) chan_b_q <= reg_wdata;
        end
    end

    // counter, prescaler and direction
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q    <= DATA_RST;
            pre_q    <= 3'h0;
            dir_dn_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            pre_q    <= (!run || pre_tick) ? 3'h0 : pre_q + 3'h1;
            dir_dn_q <= dir_dn_d;
        end
    end

    // match record: set wins over the clearing status read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= cyc_irq_d | (hit_q & ~rd_stat); // [RULE1]
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q    <= 16'h0000;
            pwm_act_q  <= 1'b0;
            pwm_ok_q   <= 1'b0;
            pwm_q      <= 1'b0;
            cyc_irq_q  <= 1'b0;
            duty_irq_q <= 1'b0;
            a_irq_q    <= 1'b0;
            b_irq_q    <= 1'b0;
        end else begin
            rdata_q    <= reg_rd ? rd_mux : 16'h0000;
            pwm_act_q  <= pwm_act_d;
            pwm_ok_q   <= pwm_ok_d;
            pwm_q      <= pwm_d;
            cyc_irq_q  <= cyc_irq_d;
            duty_irq_q <= duty_irq_d;
            a_irq_q    <= a_irq_d;
            b_irq_q    <= b_irq_d;
        end
    end

    assign reg_rdata       = rdata_q;
    assign pwm_out         = pwm_q;
    assign cycle_match_irq = cyc_irq_q;
    assign duty_match_irq  = duty_irq_q;
    assign channel_a_irq   = a_irq_q;
    assign channel_b_irq   = b_irq_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_pwm_wrap;
        run && !udc && step && hit_cyc;
    endsequence
    sequence s_cleared_with_irq;
        cnt_q == DATA_RST && cycle_match_irq;
    endsequence

    property p_pwm_cycle;
        s_pwm_wrap |=> s_cleared_with_irq;
    endproperty
    a_pwm_cycle: assert property (p_pwm_cycle) // [RULE1]
        else $error("no pwm wrap");

    property p_pwm_duty;
        run && !udc && step && hit_duty |=> duty_match_irq;
    endproperty
    a_pwm_duty: assert property (p_pwm_duty) // [RULE2]
        else $error("no duty irq");

    property p_first_period;
        $rose(run) |=> (pwm_out == alvt) throughout (!pwm_ok_q)[*2];
    endproperty
    a_first_period: assert property (p_first_period) // [RULE5]
        else $error("early pwm");

    property p_mode2_hold;
        run && udc && m2 && ci && cd && !ext_clr |=> $stable(cnt_q);
    endproperty
    a_mode2_hold: assert property (p_mode2_hold) // [RULE9]
        else $error("mode 2 hold");

    property p_mode1_down;
        run && udc && !subb && m1 && ci && b_lvl && !at_zero && !ext_clr
        |=> cnt_q == $past(cnt_q) - 16'h0001;
    endproperty
    a_mode1_down: assert property (p_mode1_down) // [RULE7]
        else $error("mode 1 down");

    property p_quad_keep;
        run && udc && m4 && qa && qb |=> dir_dn_q == $past(dir_dn_q);
    endproperty
    a_quad_keep: assert property (p_quad_keep) // [RULE13]
        else $error("mode 4 hold");

    property p_reload;
        run && udc && !subb && rld && step && dn && at_zero && !ext_clr
        |=> cnt_q == $past(cycle_compare_q);
    endproperty
    a_reload: assert property (p_reload) // [RULE16]
        else $error("no reload");

    property p_subb_down_clear;
        run && udc && subb && step && dn && hit_duty
        |=> cnt_q == DATA_RST && duty_match_irq && !cycle_match_irq;
    endproperty
    a_subb_down_clear: assert property (p_subb_down_clear) // [RULE18]
        else $error("sub-mode B clear");

    property p_capture_a;
        cap_a |=> chan_a_q == $past(cnt_q) && channel_a_irq;
    endproperty
    a_capture_a: assert property (p_capture_a) // [RULE20]
        else $error("capture a");
endmodule // udt_top

// [verif/udt_enc_model.sv]
`timescale 1ns/1ps
// Purpose: encoder and trigger source
// Assumes: bench hands over whole pin sets
// Notes:   levels outlast the synchroniser
module udt_enc_model (
    // clock
    input  wire logic       clk_sys,
    // pins: trigger b, trigger a, clear, direction, count
    output logic      [4:0] pins
);
    // ==========================================================
    // pin driver
    // idle low
    initial pins = 5'h00;
    // new level right after an edge, held five clocks
    task automatic put(input logic [4:0] v);
        @(posedge clk_sys);
        pins <= v;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // udt_enc_model

// [verif/updown_timer_pwm_quadrature_tb.sv]
`timescale 1ns/1ps
// Purpose: self-checking bench for the up/down timer
// Assumes: pins from the encoder model
// Notes:   counter expected from a behavioural model
module updown_timer_pwm_quadrature_tb import udt_pkg::*;;
    // ==========================================================
    // signals and model state
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata, v;
    logic [4:0]  pins;
    logic [4:0]  pv = 5'h00;
    logic        pwm_out, cyc_irq, duty_irq, cha_irq, chb_irq;
    logic [1:0]  gq [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [31:0] seed = 32'hC5F2;
    int n_fail = 0, checked = 0, n_cyc = 0, n_duty = 0, n_cha = 0, n_chb = 0;
    int exp_cnt, e_cyc, e_duty, qi, last_d, cyc, duty, ph, n, b1, b2, d;
    int sq_r [6] = '{1, 1, -1, -1, -1, -1};
    int sq_b [10] = '{1, 1, 1, 1, 1, 1, 1, 1, -1, -1};
    bit sub_b, rld;

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    udt_top uut (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .count_input_pin(pins[PIN_CNT]),
        .direction_input_pin(pins[PIN_DIR]),
        .external_clear_pin(pins[PIN_CLR]),
        .trigger_input_a(pins[PIN_TRA]), .trigger_input_b(pins[PIN_TRB]),
        .pwm_out(pwm_out), .cycle_match_irq(cyc_irq),
        .duty_match_irq(duty_irq), .channel_a_irq(cha_irq),
        .channel_b_irq(chb_irq)
    );
    udt_enc_model enc (.clk_sys(clk_sys), .pins(pins));

    // interrupt pulse tallies
    always @(posedge clk_sys) begin
        n_cyc  <= n_cyc + cyc_irq;
        n_duty <= n_duty + duty_irq;
        n_cha  <= n_cha + cha_irq;
        n_chb  <= n_chb + chb_irq;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [15:0] ctl(input logic [2:0] dm,
                                        input logic [15:0] x);
        return {6'h00, dm, 7'h03} | x;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] r);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        r = reg_rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd(a, v);
        chk(v, e);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    // expected counter step: d is +1 up, -1 down, 0 held
    function automatic void mstep(input int dd);
        if (dd == 0) return;
        if (sub_b && dd > 0 && exp_cnt == cyc) begin
            exp_cnt = 0;
            e_cyc++;
        end else if (sub_b && dd < 0 && exp_cnt == duty) begin
            exp_cnt = 0;
            e_duty++;
        end else if (!sub_b && rld && dd < 0 && exp_cnt == 0)
            exp_cnt = cyc;
        else
            exp_cnt = (exp_cnt + dd) & 16'hFFFF;
    endfunction
    // one pin event in decode mode m
    task automatic ev(input int m, input int dd);
        case (m)
            1, 3: begin
                pv[PIN_DIR] = (m == 1) ? (dd < 0) : (dd > 0);
                enc.put(pv);
                pv[PIN_CNT] = 1'b1;
                enc.put(pv);
                pv[PIN_CNT] = 1'b0;
                enc.put(pv);
            end
            2: begin
                pv[PIN_CNT] = (dd >= 0);
                pv[PIN_DIR] = (dd <= 0);
                enc.put(pv);
                pv[1:0] = 2'h0;
                enc.put(pv);
            end
            default: begin
                if (dd == 0) begin
                    qi = (qi + 2) % 4;
                    dd = last_d;
                end else
                    qi = (qi + dd + 4) % 4;
                pv[1:0] = gq[qi];
                enc.put(pv);
            end
        endcase
        mstep(dd);
        if (dd != 0) last_d = dd;
    endtask
    // stop, program, idle the pins, then run
    task automatic start(input logic [15:0] c, input logic [15:0] e,
                         input logic [15:0] cy, input logic [15:0] du);
        wr(REG_CTRL, c & 16'hFFFE);
        wr(REG_EDGE, e);
        wr(REG_CYC, cy);
        wr(REG_DUTY, du);
        cyc = cy;
        duty = du;
        pv = 5'h00;
        enc.put(pv);
        exp_cnt = 0;
        qi = 0;
        last_d = 0;
        e_cyc = 0;
        e_duty = 0;
        b1 = n_cyc;
        b2 = n_duty;
        wr(REG_CTRL, c);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        rchk(REG_CTRL, CTRL_RST);
        rchk(REG_CYC, DATA_RST);
        rchk(4'hF, 16'h0000);
        done("reset");
        // pwm: period 3, duty 1, first period stays inactive
        wr(REG_CYC, 16'h0003);
        wr(REG_DUTY, 16'h0001);
        wr(REG_CTRL, 16'h0001);
        ph = 0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (cyc_irq !== 1'b1) ph += pwm_out;
        end while (cyc_irq !== 1'b1 && n < 100);
        chk(16'(ph), 16'h0000);
        b2 = n_duty;
        ph = 0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            ph += pwm_out;
        end while (cyc_irq !== 1'b1 && n < 100);
        chk(16'(n), 16'h0008);
        chk(16'(ph > 0 && ph < 8), 16'h0001);
        chk(16'(n_duty - b2), 16'h0001);
        wr(REG_CTRL, 16'h0000);
        rd(REG_STAT, v);
        chk(16'(v[STA_HIT]), 16'h0001);
        rd(REG_STAT, v);
        chk(16'(v[STA_HIT]), 16'h0000);
        done("pwm");
        // all four decode modes with random steps, sub-mode A
        for (int m = 1; m <= 4; m++) begin
            start(ctl(3'(m + 3), 16'h0000), (m == 2) ? 16'h0005 : 16'h0001,
                  16'h8000, 16'h8000);
            for (int i = 0; i < 12; i++) begin
                seed = xs(seed);
                if (m == 2 || (m == 4 && i > 0)) d = int'(seed % 3) - 1;
                else d = seed[0] ? 1 : -1;
                ev(m, d);
            end
            rd(REG_CNT, v);
            case (m)
                1: chk(v, 16'(exp_cnt));
                2: chk(v, 16'(exp_cnt));
                3: chk(v, 16'(exp_cnt));
                default: chk(v, 16'(exp_cnt));
            endcase
            rd(REG_STAT, v);
            if (m != 2) chk(16'(v[STA_DIR]), 16'(last_d < 0));
        end
        done("decode");
        // reload on a down step taken at zero
        rld = 1;
        start(ctl(3'h4, 16'h0028), 16'h0001, 16'h0005, 16'h8000);
        foreach (sq_r[i]) ev(1, sq_r[i]);
        rchk(REG_CNT, 16'(exp_cnt));
        pv[PIN_CLR] = 1'b1;
        enc.put(pv);
        rchk(REG_CNT, 16'h0000);
        done("reload");
        // sub-mode B clears and interrupts
        rld = 0;
        sub_b = 1;
        start(ctl(3'h4, 16'h0004), 16'h0001, 16'h0004, 16'h0002);
        foreach (sq_b[i]) ev(1, sq_b[i]);
        rchk(REG_CNT, 16'(exp_cnt));
        chk(16'(n_cyc - b1), 16'(e_cyc));
        chk(16'(n_duty - b2), 16'(e_duty));
        done("submode_b");
        // channel b compare, channel a capture, then b capture on b fall
        sub_b = 0;
        wr(REG_CTRL, 16'h0800);
        wr(REG_CHB, 16'h0002);
        start(ctl(3'h4, 16'h0800), 16'h0091, 16'h8000, 16'h8000);
        b1 = n_chb;
        for (int i = 0; i < 4; i++) ev(1, 1);
        chk(16'(n_chb - b1), 16'h0001);
        b2 = n_cha;
        pv[PIN_TRA] = 1'b1;
        enc.put(pv);
        pv[PIN_TRA] = 1'b0;
        enc.put(pv);
        rchk(REG_CHA, 16'(exp_cnt));
        chk(16'(n_cha - b2), 16'h0001);
        wr(REG_CTRL, ctl(3'h4, 16'h1000));
        pv[PIN_TRB] = 1'b1;
        enc.put(pv);
        ev(1, 1);
        pv[PIN_TRB] = 1'b0;
        enc.put(pv);
        rchk(REG_CHB, 16'(exp_cnt));
        chk(16'(n_chb - b1), 16'h0002);
        done("channels");
        give_verdict();
    end
endmodule // updown_timer_pwm_quadrature_tb
